// file: verilog/scs_defines.svh
// Offsets, field positions, codes and reset values of the clock select block
// Assumes inclusion by its bare name; definitions only
`ifndef SCS_DEFINES_SVH
`define SCS_DEFINES_SVH
`define SCS_OFF_REQ 12'h000
`define SCS_OFF_CUR 12'h004
`define SCS_OFF_HOLD 12'h008
`define SCS_OFF_RDY 12'h00C
`define SCS_OFF_EN 12'h010
`define SCS_OFF_FRQ 12'h014
`define SCS_SRC_EXT 3'h7
`define SCS_SRC_HF 3'h6
`define SCS_SRC_LF 3'h5
`define SCS_SRC_EXT_PLL 3'h2
`define SCS_SRC_HF_PLL 3'h1
`define SCS_CFG_HF32 3'h0
`define SCS_DIV_MAX 4'h9
`define SCS_DIV_HF_RST 4'h2
`define SCS_DIV_RST 4'h0
`define SCS_FRQ_HF_RST 3'h2
`define SCS_FRQ_HF32_RST 3'h6
`define SCS_FRQ_RSVD 3'h7
`define SCS_HOLD_BIT 7
`define SCS_DONE_BIT 4
`define SCS_NRDY_BIT 3
`define SCS_EN_MASK 8'hF4
`define SCS_ZERO8 8'h00
`endif

// file: verilog/scs_pkg.sv
// Types shared by the clock select block
// Assumes the defines header is compiled alongside
package scs_pkg;
  typedef enum logic [1:0] {SCS_IDLE, SCS_WAIT, SCS_HELD} scs_state_t;
  typedef struct packed {
    logic [2:0] src;
    logic [3:0] div;
  } scs_sel_t;
endpackage

// file: verilog/scs_apb_if.sv
// Register access carrier between APB front end and register core
// Assumes one clock domain
`timescale 1ns/10ps
interface scs_apb_if;
  logic wr;
  logic rd;
  logic [11:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic hit;
  modport front (output wr, output rd, output addr, output wdata, input rdata, input hit);
  modport core (input wr, input rd, input addr, input wdata, output rdata, output hit);
endinterface

// file: verilog/scs_apb_front.sv
// APB slave front end, zero wait state, flags unmapped addresses
// Assumes the register core decodes and returns hit
`timescale 1ns/10ps
module scs_apb_front (
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic pslverr,
  output logic [31:0] prdata,
  // Core side
  scs_apb_if.front rif
);
  logic access;
  assign access = psel & penable;
  assign pready = 1'b1;
  assign pslverr = access & ~rif.hit;
  assign rif.addr = paddr;
  assign rif.wdata = pwdata[7:0];
  // Low byte lane must be enabled for a write to land
  assign rif.wr = access & pwrite & pstrb[0];
  assign rif.rd = access & ~pwrite;
  assign prdata = rif.rd ? {24'h00_0000, rif.rdata} : 32'h0000_0000;
endmodule

// file: verilog/scs_top.sv
// System clock source and postscaler select registers with switch sequencing
// Assumes oscillator ready inputs synchronous to MCLK; config fields stable
//
// Contract
// - Request source codes map to clock sources
// - Divider codes 0-9 divide by powers of two
// - Reserved source writes discarded whole
// - Switch disabled makes request register read-only
// - Request source resets from configured reset source
// - Divider resets 0010 for source 110
// - Current register shows source and divider used
// - Current fields reset equal to request
// - Hold suspends switch and raises flag
// - Hold clear at ready performs the switch
// - Switch done reads request equals current
// - New ready only while pending and ready
// - Ready flag per oscillator at fixed bits
// - PLL ready only when enabled, fed, locked
// - Manual enables force oscillators on, reset 0
// - Forced oscillators use configured mode, frequency
// - Frequency code selects fast oscillator rate
// - Frequency code resets from reset source config
// - Unimplemented bits read zero, ignore writes
// - Switch updates current, done, clears ready
// - Ready sets completion flag with new ready
`timescale 1ns/10ps
`include "scs_defines.svh"
module scs_top
  import scs_pkg::*;
(
  // Clock and reset
  input wire logic MCLK,
  input wire logic RST_N,
  // APB
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic PREADY,
  output logic PSLVERR,
  output logic [31:0] PRDATA,
  // Configuration
  input wire logic [2:0] RESET_SOURCE_CONFIG,
  input wire logic SWITCH_ENABLE_CONFIG,
  input wire logic [2:0] EXT_OSC_MODE_CONFIG,
  // Oscillator status
  input wire logic EXT_OSC_READY,
  input wire logic FAST_INT_READY,
  input wire logic MID_INT_READY,
  input wire logic SLOW_INT_READY,
  input wire logic RC_OSC_READY,
  input wire logic PLL_ENABLED,
  input wire logic PLL_LOCKED,
  // Oscillator control
  output logic EXT_OSC_FORCE_ON,
  output logic [2:0] EXT_OSC_MODE,
  output logic FAST_INT_FORCE_ON,
  output logic [2:0] FAST_INT_FREQ_CODE,
  output logic MID_INT_FORCE_ON,
  output logic SLOW_INT_FORCE_ON,
  output logic RC_OSC_FORCE_ON,
  output logic [2:0] REQUESTED_SOURCE,
  // Clock multiplexer
  output logic [2:0] CURRENT_SOURCE,
  output logic [3:0] CURRENT_DIVIDER,
  output logic SWITCH_COMPLETE_FLAG
);
  scs_apb_if rif ();

  scs_apb_front u_front (
    .psel(PSEL),
    .penable(PENABLE),
    .pwrite(PWRITE),
    .paddr(PADDR),
    .pwdata(PWDATA),
    .pstrb(PSTRB),
    .pready(PREADY),
    .pslverr(PSLVERR),
    .prdata(PRDATA),
    .rif(rif)
  );

  scs_sel_t req_q, req_d;
  scs_sel_t cur_q, cur_d;
  logic hold_q, hold_d;
  logic [7:0] en_q, en_d;
  logic [2:0] frq_q, frq_d;
  logic flag_q, flag_d;
  logic nrdy_q, nrdy_d;
  logic init_q, init_d;
  scs_state_t st_q, st_d;
  logic pending;
  logic src_ready;
  logic pll_ready;
  logic pll_in_ready;
  logic [2:0] wsrc;
  logic wsrc_ok;
  logic [7:0] ready_flags;
  logic [7:0] rdata;
  logic hit;

  // PLL usable only with lock and a ready input
  always_comb begin
    unique case (req_q.src)
      `SCS_SRC_EXT_PLL: pll_in_ready = EXT_OSC_READY;
      default: pll_in_ready = FAST_INT_READY;
    endcase
  end
  assign pll_ready = PLL_ENABLED & PLL_LOCKED & pll_in_ready;

  always_comb begin
    unique case (req_q.src)
      `SCS_SRC_EXT: src_ready = EXT_OSC_READY;
      `SCS_SRC_HF: src_ready = FAST_INT_READY;
      `SCS_SRC_LF: src_ready = SLOW_INT_READY;
      `SCS_SRC_EXT_PLL: src_ready = pll_ready;
      `SCS_SRC_HF_PLL: src_ready = pll_ready;
      default: src_ready = 1'b0;
    endcase
  end

  assign pending = (req_q != cur_q);

  assign wsrc = rif.wdata[6:4];
  always_comb begin
    unique case (wsrc)
      `SCS_SRC_EXT, `SCS_SRC_HF, `SCS_SRC_LF, `SCS_SRC_EXT_PLL, `SCS_SRC_HF_PLL: wsrc_ok = 1'b1;
      default: wsrc_ok = 1'b0;
    endcase
  end

  assign ready_flags = {EXT_OSC_READY, FAST_INT_READY, MID_INT_READY, SLOW_INT_READY, 1'b0, RC_OSC_READY,
                        1'b0, pll_ready};

  // Register state and switch sequencing
  always_comb begin
    req_d = req_q;
    cur_d = cur_q;
    hold_d = hold_q;
    en_d = en_q;
    frq_d = frq_q;
    flag_d = 1'b0;
    nrdy_d = nrdy_q;
    init_d = 1'b0;
    st_d = st_q;
    if (init_q) begin
      // Catch configuration after reset release
      req_d.src = RESET_SOURCE_CONFIG;
      req_d.div = (RESET_SOURCE_CONFIG == `SCS_SRC_HF) ? `SCS_DIV_HF_RST : `SCS_DIV_RST;
      cur_d.src = RESET_SOURCE_CONFIG;
      cur_d.div = (RESET_SOURCE_CONFIG == `SCS_SRC_HF) ? `SCS_DIV_HF_RST : `SCS_DIV_RST;
      if (RESET_SOURCE_CONFIG == `SCS_SRC_HF) begin
        frq_d = `SCS_FRQ_HF_RST;
      end else if (RESET_SOURCE_CONFIG == `SCS_CFG_HF32) begin
        frq_d = `SCS_FRQ_HF32_RST;
      end
    end else begin
      if (rif.wr) begin
        unique case (rif.addr)
          `SCS_OFF_REQ: begin
            // Divider codes above 9 are reserved; stored as written
            if (SWITCH_ENABLE_CONFIG && wsrc_ok) begin
              req_d.src = wsrc;
              req_d.div = rif.wdata[3:0];
            end
          end
          `SCS_OFF_HOLD: hold_d = rif.wdata[`SCS_HOLD_BIT];
          `SCS_OFF_EN: en_d = rif.wdata & `SCS_EN_MASK;
          `SCS_OFF_FRQ: frq_d = rif.wdata[2:0];
          default: ;
        endcase
      end
      unique case (st_q)
        SCS_IDLE: begin
          nrdy_d = 1'b0;
          if (pending) begin
            st_d = SCS_WAIT;
          end
        end
        SCS_WAIT: begin
          if (!pending) begin
            st_d = SCS_IDLE;
          end else if (src_ready) begin
            flag_d = 1'b1;
            if (hold_q) begin
              nrdy_d = 1'b1;
              st_d = SCS_HELD;
            end else begin
              cur_d = req_q;
              nrdy_d = 1'b0;
              st_d = SCS_IDLE;
            end
          end
        end
        SCS_HELD: begin
          nrdy_d = src_ready & pending;
          if (!pending) begin
            nrdy_d = 1'b0;
            st_d = SCS_IDLE;
          end else if (!src_ready) begin
            st_d = SCS_WAIT;
          end else if (!hold_q) begin
            cur_d = req_q;
            nrdy_d = 1'b0;
            st_d = SCS_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      req_q <= '0;
      cur_q <= '0;
      hold_q <= 1'b0;
      en_q <= `SCS_ZERO8;
      frq_q <= `SCS_FRQ_HF_RST;
      flag_q <= 1'b0;
      nrdy_q <= 1'b0;
      init_q <= 1'b1;
      st_q <= SCS_IDLE;
    end else begin
      req_q <= req_d;
      cur_q <= cur_d;
      hold_q <= hold_d;
      en_q <= en_d;
      frq_q <= frq_d;
      flag_q <= flag_d;
      nrdy_q <= nrdy_d;
      init_q <= init_d;
      st_q <= st_d;
    end
  end

  // Read mux; unimplemented bits zero
  always_comb begin
    rdata = `SCS_ZERO8;
    hit = 1'b1;
    unique case (rif.addr)
      `SCS_OFF_REQ: rdata = {1'b0, req_q.src, req_q.div};
      `SCS_OFF_CUR: rdata = {1'b0, cur_q.src, cur_q.div};
      `SCS_OFF_HOLD: begin
        rdata[`SCS_HOLD_BIT] = hold_q;
        rdata[`SCS_DONE_BIT] = ~pending;
        rdata[`SCS_NRDY_BIT] = nrdy_q & pending;
      end
      `SCS_OFF_RDY: rdata = ready_flags;
      `SCS_OFF_EN: rdata = en_q;
      `SCS_OFF_FRQ: rdata = {5'h00, frq_q};
      default: hit = 1'b0;
    endcase
  end
  assign rif.rdata = rdata;
  assign rif.hit = hit;

  // Oscillator controls
  assign EXT_OSC_FORCE_ON = en_q[7];
  assign FAST_INT_FORCE_ON = en_q[6];
  assign MID_INT_FORCE_ON = en_q[5];
  assign SLOW_INT_FORCE_ON = en_q[4];
  assign RC_OSC_FORCE_ON = en_q[2];
  assign EXT_OSC_MODE = EXT_OSC_MODE_CONFIG;
  assign FAST_INT_FREQ_CODE = frq_q;
  assign REQUESTED_SOURCE = req_q.src;
  assign CURRENT_SOURCE = cur_q.src;
  assign CURRENT_DIVIDER = cur_q.div;
  assign SWITCH_COMPLETE_FLAG = flag_q;
endmodule

// file: bench/scs_top_sva.sv
// Port-level checker for the clock select registers
// Assumes defines header on the include path
`timescale 1ns/10ps
`include "scs_defines.svh"
module scs_top_sva (
  // Clock, reset, bus
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic PSLVERR,
  input wire logic [31:0] PRDATA,
  // Config and clock selection
  input wire logic SWITCH_ENABLE_CONFIG,
  input wire logic [2:0] EXT_OSC_MODE_CONFIG,
  input wire logic [2:0] EXT_OSC_MODE,
  input wire logic [2:0] REQUESTED_SOURCE,
  input wire logic [2:0] CURRENT_SOURCE,
  input wire logic SWITCH_COMPLETE_FLAG
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  sequence s_rd(a);
    PSEL && PENABLE && !PWRITE && PADDR == a;
  endsequence
  AST_REQ_RD: assert property (s_rd(`SCS_OFF_REQ) |-> PRDATA[31:7] == 0 && PRDATA[6:4] == REQUESTED_SOURCE)
    else $error("request read wrong");
  AST_CUR_RD: assert property (s_rd(`SCS_OFF_CUR) |-> PRDATA[31:7] == 0 && PRDATA[6:4] == CURRENT_SOURCE)
    else $error("current read wrong");
  // Two edges after release skipped: the first one loads request and current from config
  AST_LOCK: assert property ($past(RST_N, 2) && !SWITCH_ENABLE_CONFIG |-> $stable(REQUESTED_SOURCE))
    else $error("locked request changed");
  AST_RSVD: assert property ($past(RST_N, 2) && $changed(REQUESTED_SOURCE) |-> !(REQUESTED_SOURCE inside {3'h0, 3'h3, 3'h4}))
    else $error("reserved source stored");
  AST_CUR: assert property ($past(RST_N, 2) && $changed(CURRENT_SOURCE) |-> CURRENT_SOURCE == $past(REQUESTED_SOURCE))
    else $error("current not from request");
  AST_PULSE: assert property (SWITCH_COMPLETE_FLAG |=> !SWITCH_COMPLETE_FLAG)
    else $error("flag longer than a cycle");
  AST_MODE: assert property (EXT_OSC_MODE == EXT_OSC_MODE_CONFIG)
    else $error("mode not passed");
  AST_UNMAP: assert property (PSEL && PENABLE && PADDR > `SCS_OFF_FRQ |-> PSLVERR && PRDATA == 0)
    else $error("unmapped access wrong");
endmodule
bind scs_top scs_top_sva u_sva (.MCLK, .RST_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PSLVERR, .PRDATA,
  .SWITCH_ENABLE_CONFIG, .EXT_OSC_MODE_CONFIG, .EXT_OSC_MODE, .REQUESTED_SOURCE, .CURRENT_SOURCE,
  .SWITCH_COMPLETE_FLAG);

// file: bench/testbench.sv
// Self-checking bench for the clock select registers
// Assumes scs_top and its checker compiled first
`timescale 1ns/10ps
`include "scs_defines.svh"
module testbench;
  logic MCLK, RST_N, PSEL, PENABLE, PWRITE, SWITCH_ENABLE_CONFIG, PREADY, PSLVERR, SWITCH_COMPLETE_FLAG;
  logic EXT_OSC_READY, FAST_INT_READY, MID_INT_READY, SLOW_INT_READY, RC_OSC_READY, PLL_ENABLED, PLL_LOCKED;
  logic EXT_OSC_FORCE_ON, FAST_INT_FORCE_ON, MID_INT_FORCE_ON, SLOW_INT_FORCE_ON, RC_OSC_FORCE_ON;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA, r, v;
  logic [3:0] PSTRB, CURRENT_DIVIDER;
  logic [2:0] RESET_SOURCE_CONFIG, EXT_OSC_MODE_CONFIG, EXT_OSC_MODE, FAST_INT_FREQ_CODE;
  logic [2:0] REQUESTED_SOURCE, CURRENT_SOURCE;
  int fails, samples_checked, d, ms, md, cs, cd, fq;
  scs_top dut (.MCLK, .RST_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PSTRB, .PREADY, .PSLVERR, .PRDATA,
    .RESET_SOURCE_CONFIG, .SWITCH_ENABLE_CONFIG, .EXT_OSC_MODE_CONFIG, .EXT_OSC_READY, .FAST_INT_READY,
    .MID_INT_READY, .SLOW_INT_READY, .RC_OSC_READY, .PLL_ENABLED, .PLL_LOCKED, .EXT_OSC_FORCE_ON, .EXT_OSC_MODE,
    .FAST_INT_FORCE_ON, .FAST_INT_FREQ_CODE, .MID_INT_FORCE_ON, .SLOW_INT_FORCE_ON, .RC_OSC_FORCE_ON,
    .REQUESTED_SOURCE, .CURRENT_SOURCE, .CURRENT_DIVIDER, .SWITCH_COMPLETE_FLAG);
  task chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      fails++;
      $display("mismatch at %0t: saw %h want %h", $time, s, e);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [7:0] x);
    @(posedge MCLK);
    PSEL <= 1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= 32'(x);
    @(posedge MCLK);
    PENABLE <= 1;
    // No wait-state count assumed; only the watchdog ends a stuck access
    do begin
      @(posedge MCLK);
    end while (PREADY !== 1'b1);
    r = PRDATA;
    PSEL <= 0;
    PENABLE <= 0;
  endtask
  task rd(input logic [11:0] a, input logic [7:0] e);
    apb(0, a, 0);
    chk(r, 32'(e));
  endtask
  task wsw();
    for (int k = 0; k < 20 && SWITCH_COMPLETE_FLAG !== 1'b1; k++) @(posedge MCLK);
    chk(SWITCH_COMPLETE_FLAG, 1);
    repeat (2) @(posedge MCLK);
  endtask
  task rst(input logic [2:0] c, input logic en);
    RESET_SOURCE_CONFIG <= c;
    SWITCH_ENABLE_CONFIG <= en;
    RST_N <= 0;
    repeat (4) @(posedge MCLK);
    RST_N <= 1;
    @(posedge MCLK);
    ms = c;
    md = (c == 6) ? 2 : 0;
    cs = ms;
    cd = md;
    fq = (c == 0) ? 6 : 2;
  endtask
  task wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    MCLK = 0;
    forever #5 MCLK = ~MCLK;
  end
  initial begin
    #100000;
    fails++;
    wrap_up();
  end
  initial begin
    {RST_N, PSEL, PENABLE, PWRITE, PADDR, PWDATA, PSTRB} = {48'h0000_0000_0000, 4'hF};
    {RESET_SOURCE_CONFIG, SWITCH_ENABLE_CONFIG} = 4'hD;
    {EXT_OSC_READY, FAST_INT_READY, MID_INT_READY, SLOW_INT_READY, RC_OSC_READY, PLL_ENABLED, PLL_LOCKED} = 7'h7F;
    void'($urandom(60561));
    EXT_OSC_MODE_CONFIG = 3'($urandom);
    for (d = 0; d < 3; d++) begin
      rst(d == 0 ? 6 : d == 1 ? 0 : 7, d != 2);
      rd(`SCS_OFF_REQ, {ms[2:0], md[3:0]});
      rd(`SCS_OFF_CUR, {cs[2:0], cd[3:0]});
      rd(`SCS_OFF_FRQ, fq[7:0]);
      rd(`SCS_OFF_HOLD, 8'h10);
      rd(`SCS_OFF_EN, 8'h00);
    end
    // Switch is locked in this last reset
    apb(1, `SCS_OFF_REQ, 8'h65);
    rd(`SCS_OFF_REQ, 8'h70);
    $display("reset test done");
    rst(6, 1);
    for (d = 0; d < 8; d++) begin
      v = $urandom_range(9, 0);
      apb(1, `SCS_OFF_REQ, {1'b1, d[2:0], v[3:0]});
      if (!(d inside {0, 3, 4})) begin
        ms = d;
        md = v;
      end
      if (ms != cs || md != cd) wsw();
      cs = ms;
      cd = md;
      rd(`SCS_OFF_REQ, {ms[2:0], md[3:0]});
      rd(`SCS_OFF_HOLD, 8'h10);
      chk({CURRENT_SOURCE, CURRENT_DIVIDER}, {cs[2:0], cd[3:0]});
    end
    $display("switch test done");
    FAST_INT_READY <= 0;
    apb(1, `SCS_OFF_HOLD, 8'h80);
    apb(1, `SCS_OFF_REQ, 8'h65);
    rd(`SCS_OFF_HOLD, 8'h80);
    FAST_INT_READY <= 1;
    wsw();
    rd(`SCS_OFF_HOLD, 8'h88);
    rd(`SCS_OFF_CUR, {cs[2:0], cd[3:0]});
    apb(1, `SCS_OFF_HOLD, 8'h00);
    repeat (2) @(posedge MCLK);
    rd(`SCS_OFF_CUR, 8'h65);
    rd(`SCS_OFF_HOLD, 8'h10);
    // Held switch dropped by copying current back into request
    apb(1, `SCS_OFF_HOLD, 8'h80);
    apb(1, `SCS_OFF_REQ, 8'h73);
    wsw();
    apb(1, `SCS_OFF_REQ, 8'h65);
    rd(`SCS_OFF_HOLD, 8'h90);
    rd(`SCS_OFF_CUR, 8'h65);
    apb(1, `SCS_OFF_HOLD, 8'h00);
    $display("hold test done");
    for (d = 0; d < 6; d++) begin
      v = $urandom;
      {EXT_OSC_READY, FAST_INT_READY, MID_INT_READY, SLOW_INT_READY, RC_OSC_READY, PLL_ENABLED, PLL_LOCKED} <= v[6:0];
      rd(`SCS_OFF_RDY, {v[6:3], 1'b0, v[2], 1'b0, v[1] & v[0] & v[5]});
      apb(1, `SCS_OFF_EN, v[15:8]);
      rd(`SCS_OFF_EN, v[15:8] & `SCS_EN_MASK);
      chk({EXT_OSC_FORCE_ON, FAST_INT_FORCE_ON, MID_INT_FORCE_ON, SLOW_INT_FORCE_ON, RC_OSC_FORCE_ON}, {v[15:12], v[10]});
      apb(1, `SCS_OFF_FRQ, v[23:16]);
      rd(`SCS_OFF_FRQ, v[18:16]);
      chk(FAST_INT_FREQ_CODE, v[18:16]);
    end
    apb(1, 12'h040, 8'hFF);
    rd(12'h040, 8'h00);
    $display("status test done");
    wrap_up();
  end
endmodule
